// [pkg/wdc_pkg.sv]
// constants, types and helpers shared by the watchdog control block
package wdc_pkg;

   // register byte offsets on the bus
   localparam logic [3:0]  WDC_CTRL_OFS      = 4'h0;
   localparam logic [3:0]  WDC_AUX_OFS       = 4'h4;

   // control/status field positions
   localparam int          WDC_FLAG_BIT      = 7;
   localparam int          WDC_IRQEN_BIT     = 6;
   localparam int          WDC_SEL3_BIT      = 5;
   localparam int          WDC_UNLOCK_BIT    = 4;
   localparam int          WDC_RSTEN_BIT     = 3;
   localparam int          WDC_SEL_LO_MSB    = 2;

   // auxiliary register field positions
   localparam int          WDC_GIE_BIT       = 0;
   localparam int          WDC_RESTART_BIT   = 1;
   localparam int          WDC_CAUSE_BIT     = 2;
   localparam int          WDC_FUSE_BIT      = 3;

   // reset values
   localparam logic [3:0]  WDC_SEL_RST       = 4'h0;
   localparam logic        WDC_BIT_RST       = 1'b0;

   // timing
   localparam logic [2:0]  WDC_UNLOCK_CYCLES = 3'h4;
   localparam int          WDC_OSC_FREQ_HZ   = 128000;
   localparam int          WDC_BASE_CYCLES   = 2048;
   localparam logic [3:0]  WDC_SEL_MAX       = 4'h9;
   localparam int          WDC_CNT_W         = 21;

   // vectors presented beside the requests
   localparam logic [15:0] WDC_RESET_VEC     = 16'h0000;
   localparam logic [15:0] WDC_IRQ_VEC       = 16'h0018;
   localparam logic [5:0]  WDC_IRQ_VEC_NO    = 6'h0D;

   typedef enum logic [1:0] {
      WDC_BUS_IDLE = 2'b01,
      WDC_BUS_ACK  = 2'b10
   } wdc_bus_t;

   // time-out length in oscillator cycles; reserved codes act as the longest one
   function automatic logic [WDC_CNT_W-1:0] wdc_limit(input logic [3:0] sel,
                                                     input logic [WDC_CNT_W-1:0] base);
      logic [3:0] s;
      s = (sel > WDC_SEL_MAX) ? WDC_SEL_MAX : sel;
      return base << s;
   endfunction

endpackage

// [pkg/wdc_cnt_if.sv]
// link between the control logic and the time-out counter
`timescale 1ns/1ns
interface wdc_cnt_if;
   logic       tick;
   logic       restart;
   logic [3:0] sel;
   logic       timeout;
   modport ctl (output tick, output restart, output sel, input timeout);
   modport cnt (input tick, input restart, input sel, output timeout);
endinterface

// [core/wdc_counter.sv]
// time-out counter on the system clock, advanced by oscillator ticks
`timescale 1ns/1ns
module wdc_counter #(
   parameter int BASE_CYCLES = 2048
) (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   wdc_cnt_if.cnt    cif
);
   import wdc_pkg::*;

   logic [WDC_CNT_W-1:0] cnt_reg;
   logic [WDC_CNT_W-1:0] cnt_next;
   logic                 to_reg;
   logic                 to_next;
   logic [WDC_CNT_W-1:0] limit;

   always_comb begin
      limit    = wdc_limit(cif.sel, WDC_CNT_W'(BASE_CYCLES));
      cnt_next = cnt_reg;
      to_next  = 1'b0;
      if (cif.restart) begin
         cnt_next = '0;
      end else if (cif.tick) begin
         // only oscillator ticks advance the count, never the system clock
         if (cnt_reg >= limit - WDC_CNT_W'(1)) begin
            cnt_next = '0;
            to_next  = 1'b1;
         end else begin
            cnt_next = cnt_reg + WDC_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
         to_reg  <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         to_reg  <= to_next;
      end
   end

   assign cif.timeout = to_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   chk_restart_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cif.restart |=> cnt_reg == '0)
      else $error("restart did not zero the count");

   // a missed tick gate would let the system clock shorten every time-out
   chk_tick_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !cif.tick && !cif.restart |=> $stable(cnt_reg) && !cif.timeout)
      else $error("count moved without an oscillator tick");

endmodule

// [core/wdc_ctrl.sv]
// watchdog control block: register slave, mode logic and time-out actions
`timescale 1ns/1ns
module wdc_ctrl #(
   parameter int BASE_CYCLES = 2048
) (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        osc_tick_i,
   input  wire logic        irq_vector_ack_i,
   input  wire logic        reset_cause_flag_i,
   input  wire logic        always_on_fuse_i,
   output logic             wdt_irq_o,
   output logic      [5:0]  wdt_irq_vector_no_o,
   output logic      [15:0] wdt_irq_vector_o,
   output logic             sys_reset_o,
   output logic      [15:0] sys_reset_vector_o
);
   import wdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave

   wdc_bus_t    bus_reg;
   wdc_bus_t    bus_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        wr_ok;
   logic        wr_ctrl;
   logic        wr_aux;
   logic [7:0]  wd;

   // control state
   logic       flag_reg, flag_next;
   logic       irqen_reg, irqen_next;
   logic       rsten_reg, rsten_next;
   logic [3:0] sel_reg, sel_next;
   logic [2:0] unl_reg, unl_next;
   logic       gie_reg, gie_next;
   logic       rst_pulse_reg, rst_pulse_next;
   logic       restart_reg, restart_next;
   logic       irq_reg, irq_next;
   logic       unlocked;
   logic       irqen_eff;
   logic       rsten_eff;
   logic       timeout;
   logic       ack_ok;

   wdc_cnt_if cif ();

   wdc_counter #(.BASE_CYCLES(BASE_CYCLES)) wdc_counter_inst (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .cif     (cif)
   );

   assign cif.tick    = osc_tick_i;
   assign cif.restart = restart_reg;
   assign cif.sel     = sel_reg;
   assign timeout     = cif.timeout;

   // a request is taken on the edge where waitrequest is seen low
   assign wr_ok   = avs_write_i && (bus_reg == WDC_BUS_ACK) && avs_byteenable_i[0];
   assign wr_ctrl = wr_ok && (avs_address_i == WDC_CTRL_OFS);
   assign wr_aux  = wr_ok && (avs_address_i == WDC_AUX_OFS);
   assign wd      = avs_writedata_i[7:0];

   assign unlocked  = (unl_reg != 3'h0);
   assign irqen_eff = irqen_reg && !always_on_fuse_i;
   assign rsten_eff = rsten_reg || reset_cause_flag_i || always_on_fuse_i;
   assign ack_ok    = irq_vector_ack_i && irq_reg;

   always_comb begin
      bus_next   = bus_reg;
      rdata_next = rdata_reg;
      unique case (bus_reg)
         WDC_BUS_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               bus_next   = WDC_BUS_ACK;
               rdata_next = 32'h0000_0000;
               if (avs_read_i && avs_address_i == WDC_CTRL_OFS) begin
                  rdata_next[WDC_FLAG_BIT]   = flag_reg;
                  rdata_next[WDC_IRQEN_BIT]  = irqen_eff;
                  rdata_next[WDC_SEL3_BIT]   = sel_reg[3];
                  rdata_next[WDC_UNLOCK_BIT] = unlocked;
                  rdata_next[WDC_RSTEN_BIT]  = rsten_eff;
                  rdata_next[WDC_SEL_LO_MSB:0] = sel_reg[2:0];
               end else if (avs_read_i && avs_address_i == WDC_AUX_OFS) begin
                  rdata_next[WDC_GIE_BIT]   = gie_reg;
                  rdata_next[WDC_CAUSE_BIT] = reset_cause_flag_i;
                  rdata_next[WDC_FUSE_BIT]  = always_on_fuse_i;
               end
            end
         end
         WDC_BUS_ACK: begin
            bus_next = WDC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         bus_reg   <= WDC_BUS_IDLE;
         rdata_reg <= 32'h0000_0000;
      end else begin
         bus_reg   <= bus_next;
         rdata_reg <= rdata_next;
      end
   end

   assign avs_readdata_o    = rdata_reg;
   // the idle code's bit is the output itself, so waitrequest leaves a flop with no decode
   assign avs_waitrequest_o = bus_reg[0];

   ////////////////////////////////////////////////////////////////////////////////
   // control register and time-out actions

   always_comb begin
      flag_next      = flag_reg;
      irqen_next     = irqen_reg;
      rsten_next     = rsten_reg;
      sel_next       = sel_reg;
      gie_next       = gie_reg;
      unl_next       = unlocked ? unl_reg - 3'h1 : 3'h0;
      rst_pulse_next = 1'b0;
      restart_next   = 1'b0;
      if (wr_ctrl) begin
         if (wd[WDC_FLAG_BIT]) begin
            flag_next = 1'b0;
         end
         irqen_next = wd[WDC_IRQEN_BIT];
         if (wd[WDC_RSTEN_BIT]) begin
            rsten_next = 1'b1;
         end else if (unlocked) begin
            rsten_next = 1'b0;
         end
         if (unlocked) begin
            sel_next = {wd[WDC_SEL3_BIT], wd[WDC_SEL_LO_MSB:0]};
         end
         if (wd[WDC_UNLOCK_BIT]) begin
            unl_next = WDC_UNLOCK_CYCLES;
         end
      end
      if (wr_aux) begin
         gie_next     = wd[WDC_GIE_BIT];
         restart_next = wd[WDC_RESTART_BIT];
      end
      if (ack_ok) begin
         flag_next = 1'b0;
         if (rsten_eff) begin
            irqen_next = 1'b0;
         end
      end
      // a time-out in the same cycle as a clear keeps the flag set if it would set the flag without the clear
      if (timeout) begin
         if (irqen_eff && !(rsten_eff && flag_reg)) begin
            flag_next = 1'b1;
         end else if (rsten_eff) begin
            rst_pulse_next = 1'b1;
         end
      end
      irq_next = flag_next && irqen_next && !always_on_fuse_i && gie_next;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         flag_reg      <= WDC_BIT_RST;
         irqen_reg     <= WDC_BIT_RST;
         rsten_reg     <= WDC_BIT_RST;
         sel_reg       <= WDC_SEL_RST;
         unl_reg       <= 3'h0;
         gie_reg       <= WDC_BIT_RST;
         rst_pulse_reg <= 1'b0;
         restart_reg   <= 1'b0;
         irq_reg       <= 1'b0;
      end else begin
         flag_reg      <= flag_next;
         irqen_reg     <= irqen_next;
         rsten_reg     <= rsten_next;
         sel_reg       <= sel_next;
         unl_reg       <= unl_next;
         gie_reg       <= gie_next;
         rst_pulse_reg <= rst_pulse_next;
         restart_reg   <= restart_next;
         irq_reg       <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   logic [15:0] ivec_reg;
   logic [5:0]  ivno_reg;
   logic [15:0] rvec_reg;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ivec_reg <= WDC_IRQ_VEC;
         ivno_reg <= WDC_IRQ_VEC_NO;
         rvec_reg <= WDC_RESET_VEC;
      end else begin
         ivec_reg <= WDC_IRQ_VEC;
         ivno_reg <= WDC_IRQ_VEC_NO;
         rvec_reg <= WDC_RESET_VEC;
      end
   end

   assign wdt_irq_o           = irq_reg;
   assign wdt_irq_vector_o    = ivec_reg;
   assign wdt_irq_vector_no_o = ivno_reg;
   assign sys_reset_o         = rst_pulse_reg;
   assign sys_reset_vector_o  = rvec_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   chk_flag_on_timeout: assert property (
      timeout && irqen_eff && !(rsten_eff && flag_reg) |=> flag_reg)
      else $error("flag not set on time-out");

   chk_ack_clears_flag: assert property (
      ack_ok && !timeout |=> !flag_reg)
      else $error("vector did not clear flag");

   chk_write_one_clear: assert property (
      wr_ctrl && wd[WDC_FLAG_BIT] && !timeout |=> !flag_reg)
      else $error("write one did not clear flag");

   chk_irq_gating: assert property (
      wdt_irq_o |-> flag_reg && irqen_reg && gie_reg && !always_on_fuse_i)
      else $error("interrupt without all enables");

   chk_irq_mode_quiet: assert property (
      timeout && irqen_eff && !rsten_eff |=> !sys_reset_o ##1 !sys_reset_o)
      else $error("reset in interrupt mode");

   chk_combined_ack: assert property (
      ack_ok && rsten_eff && !wr_ctrl |=> !irqen_reg && (!flag_reg || $past(timeout)))
      else $error("combined vector did not drop enable");

   chk_second_reset: assert property (
      timeout && irqen_eff && rsten_eff && flag_reg |=> sys_reset_o)
      else $error("no reset on unserviced time-out");

   chk_select_locked: assert property (
      wr_ctrl && !unlocked |=> $stable(sel_reg))
      else $error("select changed while locked");

   chk_unlock_expiry: assert property (
      wr_ctrl && wd[WDC_UNLOCK_BIT] |=> unlocked[*4] ##1 !unlocked)
      else $error("unlock did not expire after four cycles");

   chk_cause_readback: assert property (
      bus_reg == WDC_BUS_IDLE && avs_read_i && avs_address_i == WDC_CTRL_OFS
      && reset_cause_flag_i |=> avs_readdata_o[WDC_RSTEN_BIT])
      else $error("reset enable not forced by cause");

   chk_fuse_reset: assert property (
      timeout && always_on_fuse_i |=> sys_reset_o && !flag_reg || $past(flag_reg))
      else $error("fuse did not force reset");

   chk_combined_first: assert property (
      timeout && irqen_eff && rsten_eff && !flag_reg |=> flag_reg && !sys_reset_o)
      else $error("combined first time-out did not only flag");

   chk_stopped_quiet: assert property (
      timeout && !irqen_eff && !rsten_eff |=> !sys_reset_o && !$rose(flag_reg))
      else $error("action taken on time-out while stopped");

   cov_combined_first: cover property (timeout && irqen_eff && rsten_eff && !flag_reg);
   cov_system_reset:   cover property (sys_reset_o);
   cov_unlocked_write: cover property (wr_ctrl && unlocked && !wd[WDC_RSTEN_BIT]);
   cov_irq_serviced:   cover property (ack_ok);

endmodule

// [dv/wdc_ctrl_tb.sv]
// self-checking bench for the watchdog control block
`timescale 1ns/1ns
module wdc_ctrl_tb;
   import wdc_pkg::*;
   logic        clock_i = 1'b0, rst_n_i = 1'b0, held = 1'b0;
   logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
   logic        avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
   logic        osc_tick_i = 1'b0, irq_vector_ack_i = 1'b0;
   logic        reset_cause_flag_i = 1'b0, always_on_fuse_i = 1'b0;
   logic        avs_waitrequest_o, wdt_irq_o, sys_reset_o;
   logic [5:0]  wdt_irq_vector_no_o;
   logic [15:0] wdt_irq_vector_o, sys_reset_vector_o;
   logic [7:0]  exp_q[$];
   int          miscompares = 0, n_tests = 0, n_rst = 0, k, t0, t2, tf;

   // short base count keeps the longest time-out near 8k cycles
   wdc_ctrl #(.BASE_CYCLES(16)) wdc_ctrl_inst (.clock_i, .rst_n_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
      .avs_waitrequest_o, .osc_tick_i, .irq_vector_ack_i, .reset_cause_flag_i,
      .always_on_fuse_i, .wdt_irq_o, .wdt_irq_vector_no_o, .wdt_irq_vector_o,
      .sys_reset_o, .sys_reset_vector_o);

   always #10 clock_i = ~clock_i;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic fail;
      miscompares++;
      close_out;
   endtask

   // read results are compared by the watcher, in request order
   always @(posedge clock_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         check(avs_readdata_o, {24'h0, exp_q.pop_front()});
      end
      if (sys_reset_o === 1'b1) n_rst++;
   end

   // rel=0 keeps the strobe up so a second write follows with no idle cycle
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be, input logic rel);
      int n;
      if (!held) @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'($urandom), d};
      avs_byteenable_i <= be;
      avs_read_i <= !w;
      avs_write_i <= w;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) fail;
      held = !rel;
      if (rel) begin
         avs_read_i <= 1'b0;
         avs_write_i <= 1'b0;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF, 1'b1);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00, 4'hF, 1'b1);
   endtask

   task automatic unlock_wr(input logic [7:0] d);
      bus(1'b1, WDC_CTRL_OFS, 8'h18, 4'hF, 1'b0);
      bus(1'b1, WDC_CTRL_OFS, d, 4'hF, 1'b1);
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      while (wdt_irq_o !== 1'b1 && n < 20000) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 20000) fail;
      check(wdt_irq_vector_no_o, 32'h0D);
      check(wdt_irq_vector_o, 32'h0018);
   endtask

   task automatic wait_rst;
      int r;
      int n;
      r = n_rst;
      n = 0;
      while (n_rst == r && n < 2000) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 2000) fail;
      check(sys_reset_vector_o, 32'h0000);
   endtask

   task automatic ack;
      @(posedge clock_i);
      irq_vector_ack_i <= 1'b1;
      @(posedge clock_i);
      irq_vector_ack_i <= 1'b0;
   endtask

   // cycles from a counter restart to the interrupt, for one select code
   task automatic meas(input logic [3:0] s, output int n);
      wr(WDC_AUX_OFS, 8'h02);
      unlock_wr({2'b11, s[3], 2'b00, s[2:0]});
      wr(WDC_AUX_OFS, 8'h03);
      wait_irq(n);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h2716));
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'b1;
      osc_tick_i <= 1'b1;
      repeat (40) @(posedge clock_i);
      rd(WDC_CTRL_OFS, 8'h00);
      rd(WDC_AUX_OFS, 8'h00);
      rd(4'h8, 8'h00);
      bus(1'b1, WDC_CTRL_OFS, 8'h48, 4'h0, 1'b1);
      rd(WDC_CTRL_OFS, 8'h00);
      check(n_rst, 0);
      meas(4'hF, tf);
      rd(WDC_CTRL_OFS, 8'hE7);
      wr(WDC_AUX_OFS, 8'h00);
      repeat (2) @(posedge clock_i);
      check(wdt_irq_o, 1'b0);
      wr(WDC_AUX_OFS, 8'h01);
      repeat (2) @(posedge clock_i);
      check(wdt_irq_o, 1'b1);
      wr(WDC_CTRL_OFS, 8'h67);
      rd(WDC_CTRL_OFS, 8'hE7);
      wr(WDC_CTRL_OFS, 8'hE7);
      rd(WDC_CTRL_OFS, 8'h67);
      meas(4'h2, t2);
      meas(4'h0, t0);
      check(t2 - t0, 48);
      check(tf - t0, 8176);
      check(n_rst, 0);
      ack;
      wr(WDC_AUX_OFS, 8'h03);
      rd(WDC_CTRL_OFS, 8'h40);
      // restarts span more than one 16-cycle time-out, so a dead restart would flag
      repeat (8) wr(WDC_AUX_OFS, 8'h03);
      check(wdt_irq_o, 1'b0);
      // with the oscillator stopped the count must not move on system clocks
      osc_tick_i <= 1'b0;
      repeat (40) @(posedge clock_i);
      check(wdt_irq_o, 1'b0);
      osc_tick_i <= 1'b1;
      // combined mode: first time-out only flags, vector drops to reset mode
      wr(WDC_CTRL_OFS, 8'hC8);
      k = n_rst;
      wait_irq(t0);
      check(n_rst, k);
      ack;
      rd(WDC_CTRL_OFS, 8'h08);
      wait_rst;
      wr(WDC_AUX_OFS, 8'h03);
      wr(WDC_CTRL_OFS, 8'hC8);
      wait_irq(t0);
      wait_rst;
      // the flag left by the unserviced time-out is cleared in the same write
      wr(WDC_CTRL_OFS, 8'h85);
      rd(WDC_CTRL_OFS, 8'h08);
      // unlock still reads open in the fourth cycle after its write
      unlock_wr(8'h05);
      rd(WDC_CTRL_OFS, 8'h15);
      wr(WDC_CTRL_OFS, 8'h18);
      repeat (8) @(posedge clock_i);
      wr(WDC_CTRL_OFS, 8'h00);
      rd(WDC_CTRL_OFS, 8'h0D);
      reset_cause_flag_i <= 1'b1;
      unlock_wr(8'h05);
      rd(WDC_CTRL_OFS, 8'h1D);
      rd(WDC_AUX_OFS, 8'h05);
      reset_cause_flag_i <= 1'b0;
      unlock_wr(8'h05);
      rd(WDC_CTRL_OFS, 8'h15);
      always_on_fuse_i <= 1'b1;
      wr(WDC_CTRL_OFS, 8'h40);
      rd(WDC_CTRL_OFS, 8'h0D);
      rd(WDC_AUX_OFS, 8'h09);
      wait_rst;
      close_out;
   end
endmodule
